/* verilog/rgbp_color_pipe.sv */
// Implementation choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
module rgbp_color_pipe (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// sensor front end
	input wire logic [9:0] rawSampleIn,
	input wire logic frameActiveIn,
	input wire logic lineActiveIn,
	input wire logic sampleValidIn,
	// frame grabber
	output logic [7:0] redOut,
	output logic [7:0] greenOut,
	output logic [7:0] blueOut,
	output logic frameActiveOut,
	output logic lineActiveOut,
	output logic pixelValidOut,
	// register bus
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);
	typedef enum logic [1:0] {OS_IDLE, OS_BURST, OS_GAP, OS_TILE} rgbp_ostate_t;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] be);
		for (int i = 0; i < 4; i++) begin
			merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction

	function automatic logic [11:0] sat12(input logic [21:0] v);
		sat12 = (|v[21:12]) ? 12'hfff : v[11:0];
	endfunction

	// input synchroniser: only stage B is read
	logic [12:0] syncA, syncB;
	logic fvPrev, lvPrev, frameSeen;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			syncA <= '0;
			syncB <= '0;
		end else begin
			syncA <= {frameActiveIn, lineActiveIn, sampleValidIn, rawSampleIn};
			syncB <= syncA;
		end
	end
	wire fvS = syncB[12];
	wire lvS = syncB[11];
	wire svS = syncB[10];
	wire frameStart = fvS && !fvPrev;
	wire frameEnd = !fvS && fvPrev;
	wire lineEnd = !lvS && lvPrev;
	wire take = svS && lvS && frameSeen;

	// register file
	logic [31:0] ctrlReg, wbalReg, ccReg, tileSzReg, tileOrgReg, patCfgReg, gapReg;
	logic [31:0] sigReg;
	logic [15:0] frameCount;
	logic waitReg, patRun, sigDone;
	wire wrNow = avs_write && !waitReg;
	wire [5:0] word = avs_address[7:2];
	wire [31:0] wdata = avs_writedata;
	function automatic logic hit(input logic [7:0] ofs);
		hit = wrNow && avs_address == ofs;
	endfunction
	wire [1:0] patMode = ctrlReg[rgbp_pkg::CTRL_MODE +: 2];
	wire sigEn = ctrlReg[rgbp_pkg::CTRL_SIGEN];
	// decoded from the bus nets directly, gated by wrNow, so that these nets pulse in the answer cycle of each write
	wire runWrite = wrNow && avs_address == rgbp_pkg::OFS_CTRL && avs_byteenable[0]
		&& wdata[rgbp_pkg::CTRL_RUN];
	wire toneWe = wrNow && avs_address == rgbp_pkg::OFS_TONEWR;
	wire sigClr = wrNow && avs_address == rgbp_pkg::OFS_STATUS && avs_byteenable[0]
		&& wdata[rgbp_pkg::STAT_SIGDONE];

	// pattern source at the chain start
	logic [7:0] patFrames;
	logic [15:0] lfsr;
	logic patActive;
	logic [rgbp_pkg::XW-1:0] x, y;
	wire [9:0] patData = (patMode == rgbp_pkg::PAT_LFSR) ? lfsr[9:0] :
		(patMode == rgbp_pkg::PAT_RAMP) ? x[9:0] :
		(patMode == rgbp_pkg::PAT_FLAT) ? patCfgReg[rgbp_pkg::HI_LSB +: 10] :
		{10{x[3] ^ y[3]}};
	wire [9:0] srcData = patActive ? patData : syncB[9:0];
	wire lastRep = patFrames == patCfgReg[7:0];

	// white balance on red and blue sites, green passes at unity
	wire redSite = !y[0] && x[0];
	wire blueSite = y[0] && !x[0];
	wire [8:0] gain = redSite ? wbalReg[8:0] :
		blueSite ? wbalReg[rgbp_pkg::HI_LSB +: 9] : rgbp_pkg::GAIN_UNITY;
	wire [18:0] prod = 19'(srcData) * 19'(gain);
	wire [9:0] wbData = (|prod[18:17]) ? 10'h3ff : prod[16:7];
	rgbp_pkg::rgbp_raw_t wbPix;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fvPrev <= 1'b0;
			lvPrev <= 1'b0;
			frameSeen <= 1'b0;
			x <= '0;
			y <= '0;
			lfsr <= rgbp_pkg::LFSR_SEED;
			patActive <= 1'b0;
			patRun <= 1'b0;
			patFrames <= '0;
			frameCount <= '0;
			wbPix <= '0;
		end else begin
			fvPrev <= fvS;
			lvPrev <= lvS;
			if (frameStart) frameSeen <= 1'b1;
			if (!lvS) x <= '0;
			else if (take) x <= x + 11'h001;
			if (!fvS) y <= '0;
			else if (lineEnd) y <= y + 11'h001;
			if (frameStart) begin
				patActive <= patRun;
				lfsr <= rgbp_pkg::LFSR_SEED;
			end else if (take && patActive) begin
				lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
			end
			if (frameEnd && frameSeen) frameCount <= frameCount + 16'h0001;
			if (frameEnd && patActive) begin
				patFrames <= lastRep ? 8'h00 : patFrames + 8'h01;
				if (lastRep) patRun <= 1'b0;
			end
			if (runWrite) begin
				patRun <= 1'b1;
				patFrames <= '0;
			end
			wbPix <= {fvS && frameSeen, lvS && frameSeen, take, y[0], x[0], wbData};
		end
	end

	// tile summary: running sums per tile column and mosaic position
	logic [21:0] acc [rgbp_pkg::TILE_ACC];
	logic [11:0] tileMem [rgbp_pkg::TILE_VALS];
	logic [7:0] inX, inY;
	logic [5:0] tCol;
	logic [4:0] tRow;
	wire [7:0] ppt = tileSzReg[7:0];
	wire [7:0] lpt = tileSzReg[15:8];
	wire colIn = x >= tileOrgReg[10:0] && tCol < 6'(rgbp_pkg::TILE_COLS);
	wire rowIn = y >= tileOrgReg[rgbp_pkg::HI_LSB +: 11]
		&& tRow < 5'(rgbp_pkg::TILE_ROWS);
	wire [7:0] accIdx = {tCol, y[0], x[0]};
	wire [21:0] accNew = (inY < 8'h02 ? 22'h0 : acc[accIdx]) + 22'(wbData);
	wire [11:0] tileIdx = 12'(tRow) * 12'(rgbp_pkg::TILE_ACC) + 12'(accIdx);

	always_ff @(posedge clk) begin
		if (take && colIn && rowIn) begin
			acc[accIdx] <= accNew;
			if (inY >= lpt - 8'h02) tileMem[tileIdx] <= sat12(accNew);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || !lvS) begin
			inX <= '0;
			tCol <= '0;
		end else if (take && colIn) begin
			inX <= (inX == ppt - 8'h01) ? 8'h00 : inX + 8'h01;
			if (inX == ppt - 8'h01) tCol <= tCol + 6'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || !fvS) begin
			inY <= '0;
			tRow <= '0;
		end else if (lineEnd && rowIn) begin
			inY <= (inY == lpt - 8'h01) ? 8'h00 : inY + 8'h01;
			if (inY == lpt - 8'h01) tRow <= tRow + 5'h01;
		end
	end

	// interpolation, colour correction, tone curve
	rgbp_pkg::rgbp_rgb_t dmPix, ccPix;
	logic [2:0] toneFlags;
	logic [7:0] toneData [3];
	wire [9:0] ch [3];
	wire [9:0] toneAddr [3];
	logic [9:0] ccCh [3];
	assign ch[0] = dmPix.r;
	assign ch[1] = dmPix.g;
	assign ch[2] = dmPix.b;
	assign toneAddr[0] = ccPix.r;
	assign toneAddr[1] = ccPix.g;
	assign toneAddr[2] = ccPix.b;
	wire [11:0] lumaSum = 12'(dmPix.r) + 12'({dmPix.g, 1'b0}) + 12'(dmPix.b);
	wire [9:0] luma = lumaSum[11:2];

	rgbp_demosaic u_demosaic (
		.clk(clk),
		.rst_n(rst_n),
		.inPix(wbPix),
		.outPix(dmPix)
	);

	// saturation boost around luma; sat of zero leaves the pixel as interpolated
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_cc
			wire signed [11:0] diff = $signed({2'b00, ch[gi]}) - $signed({2'b00, luma});
			wire signed [20:0] scl = diff * $signed({1'b0, ccReg[7:0]});
			wire signed [13:0] sum = 14'($signed({4'h0, ch[gi]}) + (scl >>> 6));
			always_comb begin
				if (sum < 0) ccCh[gi] = 10'h000;
				else if (sum > 14'sd1023) ccCh[gi] = 10'h3ff;
				else ccCh[gi] = sum[9:0];
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ccPix <= '0;
			toneFlags <= '0;
		end else begin
			ccPix <= {dmPix.fv, dmPix.lv, dmPix.vld, ccCh[0], ccCh[1], ccCh[2]};
			toneFlags <= {ccPix.fv, ccPix.lv, ccPix.vld};
		end
	end

	rgbp_tone_table u_tone (
		.clk(clk),
		.wrEn(toneWe),
		.wrAddr(avs_writedata[9:0]),
		.wrData(avs_writedata[rgbp_pkg::HI_LSB +: 8]),
		.rdAddr(toneAddr),
		.rdData(toneData)
	);

	// line buffer: one bank fills while the other bursts out
	logic [23:0] obuf [2 * rgbp_pkg::LINE_MAX];
	logic [rgbp_pkg::XW-1:0] wrX, rdX, lineLen;
	logic wrBank, rdBank, tlvPrev, tfvPrev, linePending, tilePending;
	logic [15:0] gapCnt;
	logic [1:0] tileLine;
	logic [10:0] pairIdx;
	rgbp_ostate_t st;
	wire toneLineEnd = tlvPrev && !toneFlags[1];
	wire toneFrameEnd = tfvPrev && !toneFlags[2];
	wire [23:0] obufRd = obuf[{rdBank, rdX}];
	wire lastPix = rdX == lineLen - 11'h001;
	wire [15:0] gapLast = 16'(rgbp_pkg::MIN_GAP - 1) + gapReg[15:0];
	wire pairOk = pairIdx < 11'(rgbp_pkg::TILE_PAIRS);
	wire [23:0] pairData = pairOk ? {tileMem[{pairIdx, 1'b0}], tileMem[{pairIdx, 1'b1}]}
		: 24'h000000;
	wire takeLine = st == OS_IDLE && linePending;
	wire takeTile = st == OS_IDLE && !linePending && tilePending && lineLen != 0;

	always_ff @(posedge clk) begin
		if (toneFlags[0]) obuf[{wrBank, wrX}] <= {toneData[0], toneData[1], toneData[2]};
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wrX <= '0;
			wrBank <= 1'b0;
			rdBank <= 1'b0;
			lineLen <= '0;
			tlvPrev <= 1'b0;
			tfvPrev <= 1'b0;
			linePending <= 1'b0;
			tilePending <= 1'b0;
		end else begin
			tlvPrev <= toneFlags[1];
			tfvPrev <= toneFlags[2];
			if (toneLineEnd) begin
				wrX <= '0;
				lineLen <= wrX;
				wrBank <= !wrBank;
				rdBank <= wrBank;
			end else if (toneFlags[0]) begin
				wrX <= wrX + 11'h001;
			end
			linePending <= (toneLineEnd && wrX != 0) || (linePending && !takeLine);
			tilePending <= toneFrameEnd || (tilePending && !takeTile);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st <= OS_IDLE;
			rdX <= '0;
			gapCnt <= '0;
			tileLine <= '0;
			pairIdx <= '0;
			frameActiveOut <= 1'b0;
			lineActiveOut <= 1'b0;
			pixelValidOut <= 1'b0;
			{redOut, greenOut, blueOut} <= '0;
		end else begin
			case (st)
				OS_IDLE: begin
					lineActiveOut <= 1'b0;
					rdX <= '0;
					if (takeLine) begin
						st <= OS_BURST;
						frameActiveOut <= 1'b1;
					end else if (takeTile) begin
						st <= OS_TILE;
						pairIdx <= '0;
						tileLine <= '0;
					end
				end
				OS_BURST: begin
					lineActiveOut <= 1'b1;
					{redOut, greenOut, blueOut} <= obufRd;
					rdX <= rdX + 11'h001;
					gapCnt <= '0;
					if (lastPix) st <= OS_GAP;
				end
				OS_TILE: begin
					lineActiveOut <= 1'b1;
					{redOut, greenOut, blueOut} <= pairData;
					rdX <= rdX + 11'h001;
					pairIdx <= pairIdx + 11'h001;
					gapCnt <= '0;
					if (lastPix) begin
						st <= OS_GAP;
						tileLine <= tileLine + 2'h1;
					end
				end
				OS_GAP: begin
					lineActiveOut <= 1'b0;
					{redOut, greenOut, blueOut} <= '0;
					rdX <= '0;
					gapCnt <= gapCnt + 16'h0001;
					if (gapCnt >= gapLast) begin
						if (tileLine == 2'(rgbp_pkg::APPEND_LINES)) begin
							frameActiveOut <= 1'b0;
							tileLine <= '0;
							st <= OS_IDLE;
						end else if (tileLine != 0) begin
							st <= OS_TILE;
						end else begin
							st <= OS_IDLE;
						end
					end
				end
				default: st <= OS_IDLE;
			endcase
			pixelValidOut <= st == OS_BURST || st == OS_TILE;
		end
	end

	// signature checker on the output pins
	logic [31:0] misr;
	logic foPrev;
	wire misrFb = misr[31] ^ misr[21] ^ misr[1] ^ misr[0];
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			misr <= '0;
			foPrev <= 1'b0;
			sigReg <= '0;
			sigDone <= 1'b0;
		end else begin
			foPrev <= frameActiveOut;
			if (frameActiveOut && !foPrev) misr <= '0;
			else if (lineActiveOut && sigEn) begin
				misr <= {misr[30:0], misrFb} ^ {8'h00, redOut, greenOut, blueOut};
			end
			if (sigClr) sigDone <= 1'b0;
			if (foPrev && !frameActiveOut && sigEn) begin
				sigReg <= misr;
				sigDone <= 1'b1;
			end
		end
	end

	// bus slave: one wait cycle, then the answer
	logic [31:0] rdMux;
	always_comb begin
		case (word)
			6'h00: rdMux = {ctrlReg[31:1], patRun};
			6'h01: rdMux = wbalReg;
			6'h02: rdMux = ccReg;
			6'h03: rdMux = tileSzReg;
			6'h04: rdMux = tileOrgReg;
			6'h05: rdMux = patCfgReg;
			6'h07: rdMux = gapReg;
			6'h08: rdMux = sigReg;
			6'h09: rdMux = {frameCount, 13'h0000, frameActiveOut, sigDone, patRun};
			default: rdMux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			waitReg <= 1'b1;
			avs_waitrequest <= 1'b1;
			avs_readdata <= '0;
			ctrlReg <= rgbp_pkg::RST_ZERO;
			wbalReg <= rgbp_pkg::RST_WBAL;
			ccReg <= rgbp_pkg::RST_ZERO;
			tileSzReg <= rgbp_pkg::RST_TILESZ;
			tileOrgReg <= rgbp_pkg::RST_ZERO;
			patCfgReg <= rgbp_pkg::RST_ZERO;
			gapReg <= rgbp_pkg::RST_ZERO;
		end else begin
			waitReg <= !((avs_read || avs_write) && waitReg);
			avs_waitrequest <= !((avs_read || avs_write) && waitReg);
			if (avs_read && waitReg) avs_readdata <= rdMux;
			if (hit(rgbp_pkg::OFS_CTRL)) ctrlReg <= merge(ctrlReg, wdata, avs_byteenable);
			if (hit(rgbp_pkg::OFS_WBAL)) wbalReg <= merge(wbalReg, wdata, avs_byteenable);
			if (hit(rgbp_pkg::OFS_CCSAT)) ccReg <= merge(ccReg, wdata, avs_byteenable);
			if (hit(rgbp_pkg::OFS_TILESZ)) tileSzReg <= merge(tileSzReg, wdata, avs_byteenable);
			if (hit(rgbp_pkg::OFS_TILEORG)) tileOrgReg <= merge(tileOrgReg, wdata, avs_byteenable);
			if (hit(rgbp_pkg::OFS_PATCFG)) patCfgReg <= merge(patCfgReg, wdata, avs_byteenable);
			if (hit(rgbp_pkg::OFS_GAP)) gapReg <= merge(gapReg, wdata, avs_byteenable);
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_req;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_ans;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence
	property p_busAnswer;
		s_req |=> s_ans;
	endproperty
	a_busAnswer: assert property (p_busAnswer) else $error("bus answer late");
	property p_capture;
		wbPix.vld |-> $past(svS) && $past(lvS) && $past(frameSeen);
	endproperty
	a_capture: assert property (p_capture) else $error("sample taken off window");
	property p_blankReset;
		!frameSeen |-> !frameActiveOut && !lineActiveOut;
	endproperty
	a_blankReset: assert property (p_blankReset) else $error("output before frame");
	property p_unityGreen;
		take && !redSite && !blueSite && !patActive |=> wbPix.d == $past(syncB[9:0]);
	endproperty
	a_unityGreen: assert property (p_unityGreen) else $error("green not unity");
	property p_zeroFill;
		st == OS_TILE && !pairOk |=> {redOut, greenOut, blueOut} == 24'h000000;
	endproperty
	a_zeroFill: assert property (p_zeroFill) else $error("tile pad not zero");
	property p_minGap;
		$fell(lineActiveOut) |-> !lineActiveOut [*2];
	endproperty
	a_minGap: assert property (p_minGap) else $error("line gap too short");
	property p_sigCapture;
		$fell(frameActiveOut) && sigEn |=> sigReg == $past(misr) && sigDone;
	endproperty
	a_sigCapture: assert property (p_sigCapture) else $error("signature not held");
	property p_repeatStop;
		frameEnd && patActive && lastRep && !runWrite |=> !patRun;
	endproperty
	a_repeatStop: assert property (p_repeatStop) else $error("pattern overran");
	property p_frameWrap;
		st == OS_BURST |-> frameActiveOut;
	endproperty
	a_frameWrap: assert property (p_frameWrap) else $error("line outside frame");
endmodule
`default_nettype wire

/* verilog/rgbp_pkg.sv */
package rgbp_pkg;
	localparam int LINE_MAX = 2048;
	localparam int XW = 11;
	localparam int TILE_COLS = 36;
	localparam int TILE_ROWS = 24;
	localparam int TILE_ACC = TILE_COLS * 4;
	localparam int TILE_VALS = TILE_ACC * TILE_ROWS;
	localparam int TILE_PAIRS = TILE_VALS / 2;
	localparam int APPEND_LINES = 3;
	localparam int MIN_GAP = 2;
	localparam logic [8:0] GAIN_UNITY = 9'h080;
	localparam logic [15:0] LFSR_SEED = 16'hace1;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_WBAL = 8'h04;
	localparam logic [7:0] OFS_CCSAT = 8'h08;
	localparam logic [7:0] OFS_TILESZ = 8'h0c;
	localparam logic [7:0] OFS_TILEORG = 8'h10;
	localparam logic [7:0] OFS_PATCFG = 8'h14;
	localparam logic [7:0] OFS_TONEWR = 8'h18;
	localparam logic [7:0] OFS_GAP = 8'h1c;
	localparam logic [7:0] OFS_SIG = 8'h20;
	localparam logic [7:0] OFS_STATUS = 8'h24;
	localparam int CTRL_RUN = 0;
	localparam int CTRL_MODE = 1;
	localparam int CTRL_SIGEN = 3;
	localparam int STAT_SIGDONE = 1;
	localparam int HI_LSB = 16;
	localparam logic [31:0] RST_WBAL = 32'h0080_0080;
	localparam logic [31:0] RST_TILESZ = 32'h0000_1010;
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;

	typedef enum logic [1:0] {PAT_LFSR, PAT_RAMP, PAT_FLAT, PAT_CHECK} rgbp_pat_t;

	typedef struct packed {
		logic fv;
		logic lv;
		logic vld;
		logic rowOdd;
		logic colOdd;
		logic [9:0] d;
	} rgbp_raw_t;

	typedef struct packed {
		logic fv;
		logic lv;
		logic vld;
		logic [9:0] r;
		logic [9:0] g;
		logic [9:0] b;
	} rgbp_rgb_t;

	function automatic logic [7:0] toneDefault(input int i);
		real x;
		real y;
		x = i / 1023.0;
		if (x <= 0.018) begin
			y = 4.5 * x;
		end else begin
			y = 1.099 * (x ** 0.45) - 0.099;
		end
		toneDefault = 8'(int'(y * 255.0));
	endfunction
endpackage

/* verilog/rgbp_tone_table.sv */
`timescale 1ns/1ns
`default_nettype none
module rgbp_tone_table (
	// clock
	input wire logic clk,
	// table load
	input wire logic wrEn,
	input wire logic [9:0] wrAddr,
	input wire logic [7:0] wrData,
	// three lookups
	input wire logic [9:0] rdAddr [3],
	output var logic [7:0] rdData [3]
);
	logic [7:0] curve [1024];

	// power-up curve; reset does not reload it, only software writes change it
	initial begin
		for (int i = 0; i < 1024; i++) begin
			curve[i] = rgbp_pkg::toneDefault(i);
		end
	end

	always_ff @(posedge clk) begin
		if (wrEn) begin
			curve[wrAddr] <= wrData;
		end
		for (int k = 0; k < 3; k++) begin
			rdData[k] <= curve[rdAddr[k]];
		end
	end
endmodule
`default_nettype wire

/* verilog/rgbp_demosaic.sv */
`timescale 1ns/1ns
`default_nettype none
module rgbp_demosaic (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// balanced mosaic in, colour out
	input wire rgbp_pkg::rgbp_raw_t inPix,
	output var rgbp_pkg::rgbp_rgb_t outPix
);
	logic [9:0] lineA [rgbp_pkg::LINE_MAX];
	logic [9:0] lineB [rgbp_pkg::LINE_MAX];
	logic [9:0] win [3][3];
	logic [rgbp_pkg::XW-1:0] col;
	logic [1:0] rowsSeen;
	logic [1:0] flagA;
	logic [1:0] flagB;
	logic cRow, cCol, winVld, lvPrev;
	logic [9:0] r, g, b;

	function automatic logic [10:0] absd(input logic [9:0] a, input logic [9:0] c);
		absd = (a > c) ? 11'(a - c) : 11'(c - a);
	endfunction

	// smooth area: mean of four; edge: mean along the flatter direction
	function automatic logic [9:0] pick(input logic [9:0] a, input logic [9:0] b2,
			input logic [9:0] c, input logic [9:0] d, input logic [10:0] da,
			input logic [10:0] db);
		logic [11:0] s;
		s = 12'(a) + 12'(b2) + 12'(c) + 12'(d);
		if (da < db) pick = 10'((11'(a) + 11'(b2)) >> 1);
		else if (db < da) pick = 10'((11'(c) + 11'(d)) >> 1);
		else pick = s[11:2];
	endfunction

	wire [9:0] upA = lineA[col];
	wire [9:0] upB = lineB[col];
	wire [9:0] n = win[0][1];
	wire [9:0] s = win[2][1];
	wire [9:0] w = win[1][0];
	wire [9:0] e = win[1][2];
	wire [9:0] crossAvg = pick(w, e, n, s, absd(w, e), absd(n, s));
	wire [9:0] diagAvg = pick(win[0][0], win[2][2], win[0][2], win[2][0],
		absd(win[0][0], win[2][2]), absd(win[0][2], win[2][0]));
	wire [9:0] hAvg = 10'((11'(w) + 11'(e)) >> 1);
	wire [9:0] vAvg = 10'((11'(n) + 11'(s)) >> 1);
	wire greenSite = cRow == cCol;
	wire redSite = !cRow && cCol;

	always_ff @(posedge clk) begin
		if (inPix.vld) begin
			lineA[col] <= inPix.d;
			lineB[col] <= upA;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			col <= '0;
			rowsSeen <= '0;
			winVld <= 1'b0;
			lvPrev <= 1'b0;
			flagA <= '0;
			flagB <= '0;
			outPix <= '0;
		end else begin
			lvPrev <= inPix.lv;
			flagA <= {inPix.fv, inPix.lv};
			flagB <= flagA;
			winVld <= inPix.vld && col > 11'h001 && rowsSeen == 2'h2;
			if (!inPix.fv) rowsSeen <= '0;
			else if (lvPrev && !inPix.lv && rowsSeen != 2'h2) rowsSeen <= rowsSeen + 2'h1;
			if (!inPix.lv) col <= '0;
			else if (inPix.vld) col <= col + 11'h001;
			outPix <= {flagB, winVld, r, g, b};
		end
	end

	always_ff @(posedge clk) begin
		if (inPix.vld) begin
			for (int i = 0; i < 3; i++) begin
				win[i][0] <= win[i][1];
				win[i][1] <= win[i][2];
			end
			win[0][2] <= upB;
			win[1][2] <= upA;
			win[2][2] <= inPix.d;
			cRow <= !inPix.rowOdd;
			cCol <= !inPix.colOdd;
		end
	end

	// mosaic layout: even rows G R, odd rows B G
	always_comb begin
		r = win[1][1];
		g = win[1][1];
		b = win[1][1];
		if (greenSite) begin
			r = cRow ? vAvg : hAvg;
			b = cRow ? hAvg : vAvg;
		end else if (redSite) begin
			g = crossAvg;
			b = diagAvg;
		end else begin
			g = crossAvg;
			r = diagAvg;
		end
	end
endmodule
`default_nettype wire

/* testbench/rgbp_sensor_model.sv */
`timescale 1ns/1ns
`default_nettype none
module rgbp_sensor_model #(
	parameter int W = 8,
	parameter int H = 6
) (
	// clock and command
	input wire logic clk,
	input wire logic start,
	input wire logic [9:0] level,
	// sensor pins
	output logic [9:0] sample,
	output logic frameAct,
	output logic lineAct,
	output logic valid
);
	initial begin
		sample = 10'h3ff;
		frameAct = 1'b0;
		lineAct = 1'b0;
		valid = 1'b0;
		forever begin
			@(posedge clk);
			if (start) begin
				frameAct <= 1'b1;
				repeat (4) @(posedge clk);
				for (int r = 0; r < H; r++) begin
					lineAct <= 1'b1;
					valid <= 1'b1;
					sample <= level;
					repeat (W) @(posedge clk);
					lineAct <= 1'b0;
					valid <= 1'b0;
					// released data: inverse, never a stale copy
					sample <= ~level;
					// gap leaves room for each output burst
					repeat (40) @(posedge clk);
				end
				frameAct <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

/* testbench/tb_rgbp_color_pipe.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_rgbp_color_pipe;
	localparam int W = 8;
	localparam int H = 6;
	logic clk = 1'b0, rst_n = 1'b0, start = 1'b0;
	logic [9:0] raw;
	logic fa, la, sv;
	logic [7:0] red, green, blue, a = 8'h00;
	logic fo, lo, po, rd = 1'b0, wr = 1'b0, wt;
	logic [31:0] wd = 32'h0, q;
	logic [3:0] be = 4'hf;
	int num_errors = 0, comparisons = 0;
	always #20 clk = ~clk;
	rgbp_sensor_model #(.W(W), .H(H)) model (.clk(clk), .start(start), .level(10'h200),
		.sample(raw), .frameAct(fa), .lineAct(la), .valid(sv));
	rgbp_color_pipe dut (.clk(clk), .rst_n(rst_n), .rawSampleIn(raw), .frameActiveIn(fa),
		.lineActiveIn(la), .sampleValidIn(sv), .redOut(red), .greenOut(green),
		.blueOut(blue), .frameActiveOut(fo), .lineActiveOut(lo), .pixelValidOut(po),
		.avs_address(a), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
		.avs_byteenable(be), .avs_readdata(q), .avs_waitrequest(wt));
	task automatic end_of_test();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one bus cycle; waitrequest is sampled at each rising edge
	task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d,
		input logic [3:0] en, output logic [31:0] r);
		int n;
		n = 0;
		a <= ad;
		wr <= w;
		rd <= !w;
		wd <= d;
		be <= en;
		@(posedge clk);
		while (wt !== 1'b0) begin
			n++;
			if (n > 20) begin
				num_errors++;
				end_of_test();
			end
			@(posedge clk);
		end
		r = q;
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clk);
	endtask
	task automatic check_regs();
		logic [31:0] r;
		bus(0, rgbp_pkg::OFS_WBAL, 0, 4'hf, r);
		cmp(r, rgbp_pkg::RST_WBAL);
		bus(0, rgbp_pkg::OFS_TILESZ, 0, 4'hf, r);
		cmp(r, rgbp_pkg::RST_TILESZ);
		bus(0, rgbp_pkg::OFS_CCSAT, 0, 4'hf, r);
		cmp(r, rgbp_pkg::RST_ZERO);
		bus(0, 8'hfc, 0, 4'hf, r);
		cmp(r, rgbp_pkg::RST_ZERO);
		bus(1, rgbp_pkg::OFS_WBAL, 32'hffff_ffff, 4'h1, r);
		bus(0, rgbp_pkg::OFS_WBAL, 0, 4'hf, r);
		cmp(r, 32'h0080_00ff);
		bus(1, rgbp_pkg::OFS_WBAL, rgbp_pkg::RST_WBAL, 4'hf, r);
		bus(1, rgbp_pkg::OFS_GAP, 32'h0000_0005, 4'hf, r);
		bus(0, rgbp_pkg::OFS_GAP, 0, 4'hf, r);
		cmp(r, 32'h0000_0005);
		bus(1, rgbp_pkg::OFS_TONEWR, 32'h005a_0200, 4'hf, r);
		bus(0, rgbp_pkg::OFS_TONEWR, 0, 4'hf, r);
		cmp(r, rgbp_pkg::RST_ZERO);
		// 2 px by 4 lines per tile: each value sums two samples of its position
		bus(1, rgbp_pkg::OFS_TILESZ, 32'h0000_0402, 4'hf, r);
	endtask
	// flat frame through a loaded table entry; first tile line checked too
	task automatic run_frame(input logic [23:0] expPix, input logic [23:0] expTile);
		int runs, len, gap;
		runs = 0;
		len = 0;
		gap = 0;
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		for (int i = 0; i < 3000; i++) begin
			@(posedge clk);
			if (lo === 1'b1) begin
				if (len == 0) begin
					runs++;
					if (runs > 1) cmp(32'(gap >= rgbp_pkg::MIN_GAP + 5), 32'h1);
				end
				len++;
				gap = 0;
			end else begin
				if (len != 0) cmp(32'(len), 32'(W - 2));
				len = 0;
				gap++;
			end
			if (po === 1'b1 && runs <= H - 2) cmp({red, green, blue}, 32'(expPix));
			else if (po === 1'b1 && runs == H - 1) cmp({red, green, blue}, 32'(expTile));
		end
		cmp(32'(runs), 32'(H - 2 + rgbp_pkg::APPEND_LINES));
		cmp({31'h0, fo}, 32'h0);
	endtask
	// flat pattern of 0x100 replaces the sensor data for one frame, signature on
	task automatic run_pattern();
		logic [31:0] r;
		bus(1, rgbp_pkg::OFS_TONEWR, 32'h00a5_0100, 4'hf, r);
		bus(1, rgbp_pkg::OFS_PATCFG, 32'h0100_0000, 4'hf, r);
		bus(1, rgbp_pkg::OFS_CTRL, 32'h0000_000d, 4'hf, r);
		bus(0, rgbp_pkg::OFS_STATUS, 0, 4'hf, r);
		cmp(r, 32'h0001_0001);
		run_frame(24'ha5a5a5, 24'h200200);
		bus(0, rgbp_pkg::OFS_STATUS, 0, 4'hf, r);
		cmp(r, 32'h0002_0002);
		bus(1, rgbp_pkg::OFS_STATUS, 32'h0000_0002, 4'hf, r);
		bus(0, rgbp_pkg::OFS_STATUS, 0, 4'hf, r);
		cmp(r, 32'h0002_0000);
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		cmp({fo, lo, po, wt}, 32'h1);
		check_regs();
		run_frame(24'h5a5a5a, 24'h400400);
		run_pattern();
		end_of_test();
	end
endmodule
`default_nettype wire
